// ### hw/pcb_pkg.sv
// Constants and types for the program sequencer and banked data addressing block
package pcb_pkg;
   localparam int PC_W = 12;
   localparam int PMEM_DEPTH = 4096;
   localparam int PAGE_WORDS = 512;
   localparam int STACK_DEPTH = 8;
   localparam int BMEM_DEPTH = 256;
   localparam int GMEM_DEPTH = 16;
   localparam int UID_DEPTH = 16;
   localparam logic [11:0] PC_RST = 12'hFFF;
   localparam logic [7:0] FSR_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [4:0] FR_INDIRECT = 5'h00;
   localparam logic [3:0] REG_INDIRECT_PORT = 4'h0;
   localparam logic [3:0] REG_PCL = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_FSR = 4'h4;
   localparam int PAGE_LSB = 5;
   localparam int BANK_LSB = 4;
   localparam int BLOCK_BIT = 7;
   localparam logic [12:0] UID_BASE = 13'h1000;
   localparam logic [12:0] UID_LAST = 13'h100F;
   localparam logic [12:0] DEVID_ADDR = 13'h1010;
   // Arbitrary value, not a real part code
   localparam logic [11:0] DEVID_DEFAULT = 12'h5A5;

   typedef enum logic [2:0] {
      PCB_OP_NONE,
      PCB_OP_STEP,
      PCB_OP_JUMP,
      PCB_OP_CALL,
      PCB_OP_RET,
      PCB_OP_PAGE,
      PCB_OP_BANK
   } pcb_op_e;

   typedef struct packed {
      pcb_op_e op;
      logic [8:0] target;
   } pcb_seq_req_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] register_field;
      logic [7:0] wdata;
   } pcb_data_req_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [12:0] addr;
      logic [11:0] wdata;
   } pcb_prog_req_s;
endpackage : pcb_pkg

// ### hw/pcb_core.sv
// Program counter, return stack, program store and banked data memory addressing
// Behaviour
// - Program store 4K by 12, linear PC
// - Reset loads PC with 0FFFh
// - No branch: PC increments, wraps to zero
// - 512-word pages never affect incrementing
// - PC low at 02h, page bits above
// - Branches use page bits; page instruction sets them
// - Eight-entry 12-bit shifting return stack
// - Stack unreachable from data accesses
// - Sixteen banks of sixteen plus global bank
// - Register field picks indirect, direct, semi-direct
// - Indirect uses bank pointer, bank 0 unreachable
// - Direct reaches global bank, ignores pointer
// - Semi-direct: pointer high nibble, field low nibble
// - Bank instruction writes pointer bits 6:4 only
// - Pointer bit 7 selects bank block
// - 1000h-100Fh hold user code identifier
// - Hard-wired part identifier, read-only, programming only
`timescale 1ns/100ps
module pcb_core #(
   parameter logic [11:0] DEVICE_ID = pcb_pkg::DEVID_DEFAULT
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire pcb_pkg::pcb_seq_req_s seq_req_i,
   input wire pcb_pkg::pcb_data_req_s data_req_i,
   input wire pcb_pkg::pcb_prog_req_s prog_req_i,
   output logic [11:0] pc_o,
   output logic [11:0] instr_o,
   output logic [7:0] rdata_o,
   output logic [7:0] bank_pointer_o,
   output logic [2:0] page_select_o,
   output logic [11:0] prog_rdata_o
);
   logic [11:0] pc_q, pc_d;
   logic [7:0] fsr_q, status_q;
   logic [11:0] stack_q [pcb_pkg::STACK_DEPTH];
   logic [11:0] pmem [pcb_pkg::PMEM_DEPTH];
   logic [11:0] uid_mem [pcb_pkg::UID_DEPTH];
   logic [7:0] bmem [pcb_pkg::BMEM_DEPTH];
   logic [7:0] gmem [pcb_pkg::GMEM_DEPTH];
   logic [11:0] instr_q, prog_rdata_q;
   logic [7:0] rdata_q;
   logic [7:0] ea;
   logic glob, hit;
   logic pcl_wr, status_wr, fsr_wr, gen_wr, bank_wr;
   logic push, pop;
   logic [2:0] page;
   logic [4:0] fr;
   logic [7:0] gread;

   assign page = status_q[7:pcb_pkg::PAGE_LSB];
   assign fr = data_req_i.register_field;

   // Effective data address
   always_comb begin
      ea = 8'h00;
      glob = 1'b0;
      hit = 1'b1;
      if (fr == pcb_pkg::FR_INDIRECT) begin
         ea = fsr_q;
         glob = (fsr_q[7:4] == 4'h0);
         hit = (fsr_q != 8'h00);
      end else if (!fr[4]) begin
         ea = {4'h0, fr[3:0]};
         glob = 1'b1;
      end else begin
         ea = {fsr_q[7:4], fr[3:0]};
         glob = 1'b0;
      end
   end

   assign pcl_wr = data_req_i.wr && hit && glob && (ea[3:0] == pcb_pkg::REG_PCL);
   assign status_wr = data_req_i.wr && hit && glob && (ea[3:0] == pcb_pkg::REG_STATUS);
   assign fsr_wr = data_req_i.wr && hit && glob && (ea[3:0] == pcb_pkg::REG_FSR);
   assign gen_wr = data_req_i.wr && hit && !pcl_wr && !status_wr && !fsr_wr;
   assign bank_wr = gen_wr && !glob;

   // Global bank read decode; the stack has no address here
   always_comb begin
      if (ea[3:0] == pcb_pkg::REG_PCL) begin
         gread = pc_q[7:0];
      end else if (ea[3:0] == pcb_pkg::REG_STATUS) begin
         gread = status_q;
      end else if (ea[3:0] == pcb_pkg::REG_FSR) begin
         gread = fsr_q;
      end else begin
         gread = gmem[ea[3:0]];
      end
   end

   // Next program counter
   always_comb begin
      pc_d = pc_q;
      push = 1'b0;
      pop = 1'b0;
      if (pcl_wr) begin
         pc_d = {page, 1'b0, data_req_i.wdata};
      end else begin
         case (seq_req_i.op)
            pcb_pkg::PCB_OP_STEP: pc_d = pc_q + 12'h001;
            pcb_pkg::PCB_OP_JUMP: pc_d = {page, seq_req_i.target};
            pcb_pkg::PCB_OP_CALL: begin
               pc_d = {page, seq_req_i.target};
               push = 1'b1;
            end
            pcb_pkg::PCB_OP_RET: begin
               pc_d = stack_q[0];
               pop = 1'b1;
            end
            default: pc_d = pc_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pc_q <= pcb_pkg::PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // Return stack shifts one place on every push or pop; the last entry holds on a pop
   genvar gi;
   generate
      for (gi = 0; gi < pcb_pkg::STACK_DEPTH; gi++) begin : g_stack
         logic [11:0] from_above, from_below;
         if (gi == 0) begin : g_head
            assign from_above = pc_q + 12'h001;
         end else begin : g_body
            assign from_above = stack_q[gi - 1];
         end
         if (gi == pcb_pkg::STACK_DEPTH - 1) begin : g_tail
            assign from_below = stack_q[gi];
         end else begin : g_inner
            assign from_below = stack_q[gi + 1];
         end
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               stack_q[gi] <= 12'h000;
            end else if (push) begin
               stack_q[gi] <= from_above;
            end else if (pop) begin
               stack_q[gi] <= from_below;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         status_q <= pcb_pkg::STATUS_RST;
      end else if (status_wr) begin
         status_q <= data_req_i.wdata;
      end else if (seq_req_i.op == pcb_pkg::PCB_OP_PAGE) begin
         status_q[7:pcb_pkg::PAGE_LSB] <= seq_req_i.target[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fsr_q <= pcb_pkg::FSR_RST;
      end else if (fsr_wr) begin
         fsr_q <= data_req_i.wdata;
      end else if (seq_req_i.op == pcb_pkg::PCB_OP_BANK) begin
         fsr_q[6:pcb_pkg::BANK_LSB] <= seq_req_i.target[2:0];
      end
   end

   // Data memories: banked and global
   always_ff @(posedge clk_i) begin
      if (bank_wr) begin
         bmem[ea] <= data_req_i.wdata;
      end
      if (gen_wr && glob && (ea[3:0] != pcb_pkg::REG_INDIRECT_PORT)) begin
         gmem[ea[3:0]] <= data_req_i.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
      end else if (data_req_i.rd) begin
         if (!hit) begin
            rdata_q <= 8'h00;
         end else if (glob) begin
            rdata_q <= gread;
         end else begin
            rdata_q <= bmem[ea];
         end
      end
   end

   // Instruction fetch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         instr_q <= 12'h000;
      end else begin
         instr_q <= pmem[pc_q];
      end
   end

   // Programming port: store, user identifier and part identifier
   always_ff @(posedge clk_i) begin
      if (prog_req_i.wr) begin
         if (prog_req_i.addr < pcb_pkg::UID_BASE) begin
            pmem[prog_req_i.addr[11:0]] <= prog_req_i.wdata;
         end else if (prog_req_i.addr <= pcb_pkg::UID_LAST) begin
            uid_mem[prog_req_i.addr[3:0]] <= prog_req_i.wdata;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prog_rdata_q <= 12'h000;
      end else if (prog_req_i.rd) begin
         if (prog_req_i.addr < pcb_pkg::UID_BASE) begin
            prog_rdata_q <= pmem[prog_req_i.addr[11:0]];
         end else if (prog_req_i.addr <= pcb_pkg::UID_LAST) begin
            prog_rdata_q <= uid_mem[prog_req_i.addr[3:0]];
         end else if (prog_req_i.addr == pcb_pkg::DEVID_ADDR) begin
            prog_rdata_q <= DEVICE_ID;
         end else begin
            prog_rdata_q <= 12'h000;
         end
      end
   end

   assign pc_o = pc_q;
   assign instr_o = instr_q;
   assign rdata_o = rdata_q;
   assign bank_pointer_o = fsr_q;
   assign page_select_o = page;
   assign prog_rdata_o = prog_rdata_q;

   // Checks
   logic [4:0] fsr_keep;
   assign fsr_keep = {fsr_q[7], fsr_q[3:0]};
   logic step_ok, jump_ok, call_ok, ret_ok;
   assign step_ok = (seq_req_i.op == pcb_pkg::PCB_OP_STEP) && !pcl_wr;
   assign jump_ok = (seq_req_i.op == pcb_pkg::PCB_OP_JUMP) && !pcl_wr;
   assign call_ok = (seq_req_i.op == pcb_pkg::PCB_OP_CALL) && !pcl_wr;
   assign ret_ok = (seq_req_i.op == pcb_pkg::PCB_OP_RET) && !pcl_wr;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_reset_pc;
      @(posedge clk_i) disable iff (1'b0) srst_i |=> (pc_q == 12'hFFF);
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("PC not 0FFFh after reset");

   property p_step;
      step_ok |=> (pc_q == 12'($past(pc_q) + 12'h001));
   endproperty
   a_step: assert property (p_step) else $error("PC did not increment");

   property p_wrap;
      step_ok && (pc_q == 12'hFFF) |=> (pc_q == 12'h000);
   endproperty
   a_wrap: assert property (p_wrap) else $error("PC did not wrap to zero");

   property p_jump;
      jump_ok |=> (pc_q == {$past(page), $past(seq_req_i.target)});
   endproperty
   a_jump: assert property (p_jump) else $error("Branch target wrong");

   sequence s_call;
      call_ok;
   endsequence
   sequence s_ret;
      ret_ok;
   endsequence
   property p_call_ret;
      s_call ##1 s_ret |=> (pc_q == 12'($past(pc_q, 2) + 12'h001));
   endproperty
   a_call_ret: assert property (p_call_ret) else $error("Return address wrong");

   property p_pcl;
      pcl_wr |=> (pc_q[8] == 1'b0) && (pc_q[7:0] == $past(data_req_i.wdata));
   endproperty
   a_pcl: assert property (p_pcl) else $error("PC low write wrong");

   property p_bank;
      (seq_req_i.op == pcb_pkg::PCB_OP_BANK) && !fsr_wr |=>
         (fsr_keep == $past(fsr_keep)) && (fsr_q[6:4] == $past(seq_req_i.target[2:0]));
   endproperty
   a_bank: assert property (p_bank) else $error("Bank instruction touched wrong bits");

   property p_direct;
      (fr != 5'h00) && !fr[4] |-> glob && (ea == {4'h0, fr[3:0]});
   endproperty
   a_direct: assert property (p_direct) else $error("Direct address wrong");

   property p_semi;
      fr[4] |-> !glob && (ea == {fsr_q[7:4], fr[3:0]});
   endproperty
   a_semi: assert property (p_semi) else $error("Semi-direct address wrong");

   property p_indirect;
      (fr == 5'h00) && (fsr_q != 8'h00) |-> (ea == fsr_q) && (glob == (fsr_q[7:4] == 4'h0));
   endproperty
   a_indirect: assert property (p_indirect) else $error("Indirect address wrong");

   property p_page;
      (seq_req_i.op == pcb_pkg::PCB_OP_PAGE) && !status_wr |=> (page == $past(seq_req_i.target[2:0]));
   endproperty
   a_page: assert property (p_page) else $error("Page preset not applied");
endmodule : pcb_core

// ### test/pcb_decode_model.sv
// Stand-in for the instruction decode logic that drives the core's request ports
`timescale 1ns/100ps
module pcb_decode_model (
   input wire logic clk_i,
   output pcb_pkg::pcb_seq_req_s seq_req_o,
   output pcb_pkg::pcb_data_req_s data_req_o,
   output pcb_pkg::pcb_prog_req_s prog_req_o
);
   initial begin
      seq_req_o = '0;
      data_req_o = '0;
      prog_req_o = '0;
   end

   // Each request stands for one edge, then the port goes idle
   task automatic seq(input pcb_pkg::pcb_op_e op, input logic [8:0] tgt);
      @(posedge clk_i);
      seq_req_o <= '{op: op, target: tgt};
      @(posedge clk_i);
      seq_req_o <= '{op: pcb_pkg::PCB_OP_NONE, target: 9'h000};
      #1;
   endtask : seq

   // Two sequencer ops on consecutive edges, then idle
   task automatic seq2(input pcb_pkg::pcb_op_e op_a, input logic [8:0] tgt_a, input pcb_pkg::pcb_op_e op_b,
      input logic [8:0] tgt_b);
      @(posedge clk_i);
      seq_req_o <= '{op: op_a, target: tgt_a};
      @(posedge clk_i);
      seq_req_o <= '{op: op_b, target: tgt_b};
      @(posedge clk_i);
      seq_req_o <= '{op: pcb_pkg::PCB_OP_NONE, target: 9'h000};
      #1;
   endtask : seq2

   task automatic dat(input logic rd, input logic wr, input logic [4:0] fr, input logic [7:0] wd);
      @(posedge clk_i);
      data_req_o <= '{rd: rd, wr: wr, register_field: fr, wdata: wd};
      @(posedge clk_i);
      data_req_o <= '0;
      #1;
   endtask : dat

   task automatic prg(input logic rd, input logic wr, input logic [12:0] addr, input logic [11:0] wd);
      @(posedge clk_i);
      prog_req_o <= '{rd: rd, wr: wr, addr: addr, wdata: wd};
      @(posedge clk_i);
      prog_req_o <= '0;
      #1;
   endtask : prg
endmodule : pcb_decode_model

// ### test/program_counter_banked_data_addressing_tb_top.sv
// Self-checking testbench for the program sequencer and banked data addressing core
`timescale 1ns/100ps
module program_counter_banked_data_addressing_tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   int failures = 0;
   int samples_checked = 0;
   pcb_pkg::pcb_seq_req_s seq_req;
   pcb_pkg::pcb_data_req_s data_req;
   pcb_pkg::pcb_prog_req_s prog_req;
   logic [11:0] pc;
   logic [11:0] instr;
   logic [11:0] prog_rdata;
   logic [7:0] rdata;
   logic [7:0] bp;
   logic [2:0] page;
   logic [11:0] exp_pc;
   logic [11:0] stk [8];

   always #20 clk_i = ~clk_i;

   pcb_decode_model u_dec (
      .clk_i(clk_i),
      .seq_req_o(seq_req),
      .data_req_o(data_req),
      .prog_req_o(prog_req)
   );

   pcb_core dut (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .seq_req_i(seq_req),
      .data_req_i(data_req),
      .prog_req_i(prog_req),
      .pc_o(pc),
      .instr_o(instr),
      .rdata_o(rdata),
      .bank_pointer_o(bp),
      .page_select_o(page),
      .prog_rdata_o(prog_rdata)
   );

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      #1;
      chk(pc, 12'hFFF);
      chk({4'h0, bp}, 12'h000);
      chk({9'h000, page}, 12'h000);
      u_dec.seq(pcb_pkg::PCB_OP_STEP, 9'h000);
      chk(pc, 12'h000);
      // Page-boundary crossing, then the fetched word follows one cycle later
      u_dec.prg(1'b0, 1'b1, 13'h0200, 12'hABC);
      u_dec.seq(pcb_pkg::PCB_OP_JUMP, 9'h1FF);
      chk(pc, 12'h1FF);
      u_dec.seq(pcb_pkg::PCB_OP_STEP, 9'h000);
      chk(pc, 12'h200);
      @(posedge clk_i);
      #1;
      chk(instr, 12'hABC);
      u_dec.seq(pcb_pkg::PCB_OP_PAGE, 9'h005);
      chk({9'h000, page}, 12'h005);
      u_dec.seq(pcb_pkg::PCB_OP_JUMP, 9'h010);
      chk(pc, 12'hA10);
      u_dec.dat(1'b0, 1'b1, 5'h02, 8'h34);
      chk(pc, 12'hA34);
      u_dec.dat(1'b1, 1'b0, 5'h02, 8'h00);
      chk({4'h0, rdata}, 12'h034);
      // Fill the return stack with nested calls, then unwind it
      exp_pc = 12'hA34;
      for (int i = 0; i < 8; i++) begin
         stk[i] = exp_pc + 12'h001;
         u_dec.seq(pcb_pkg::PCB_OP_CALL, 9'h040 + 9'(i));
         exp_pc = {3'h5, 9'h040 + 9'(i)};
         chk(pc, exp_pc);
      end
      for (int i = 7; i >= 0; i--) begin
         u_dec.seq(pcb_pkg::PCB_OP_RET, 9'h000);
         chk(pc, stk[i]);
      end
      // Call and return on consecutive edges
      u_dec.seq2(pcb_pkg::PCB_OP_CALL, 9'h060, pcb_pkg::PCB_OP_RET, 9'h000);
      chk(pc, 12'hA36);
      // Indirect write to F5h seen again through semi-direct access
      u_dec.dat(1'b0, 1'b1, 5'h04, 8'hF5);
      chk({4'h0, bp}, 12'h0F5);
      u_dec.dat(1'b0, 1'b1, 5'h00, 8'h01);
      u_dec.dat(1'b1, 1'b0, 5'h15, 8'h00);
      chk({4'h0, rdata}, 12'h001);
      u_dec.seq(pcb_pkg::PCB_OP_BANK, 9'h002);
      chk({4'h0, bp}, 12'h0A5);
      u_dec.dat(1'b0, 1'b1, 5'h0F, 8'hAA);
      u_dec.dat(1'b1, 1'b0, 5'h0F, 8'h00);
      chk({4'h0, rdata}, 12'h0AA);
      u_dec.dat(1'b0, 1'b1, 5'h04, 8'h0F);
      u_dec.dat(1'b1, 1'b0, 5'h00, 8'h00);
      chk({4'h0, rdata}, 12'h0AA);
      // Bank 0 through semi-direct only; the global bank stays untouched
      u_dec.dat(1'b0, 1'b1, 5'h04, 8'h00);
      u_dec.dat(1'b0, 1'b1, 5'h1F, 8'h77);
      u_dec.dat(1'b1, 1'b0, 5'h0F, 8'h00);
      chk({4'h0, rdata}, 12'h0AA);
      u_dec.dat(1'b1, 1'b0, 5'h1F, 8'h00);
      chk({4'h0, rdata}, 12'h077);
      u_dec.dat(1'b0, 1'b1, 5'h00, 8'h99);
      u_dec.dat(1'b1, 1'b0, 5'h00, 8'h00);
      chk({4'h0, rdata}, 12'h000);
      u_dec.dat(1'b1, 1'b0, 5'h1F, 8'h00);
      chk({4'h0, rdata}, 12'h077);
      // Page bits written through the status register steer the next branch
      u_dec.dat(1'b0, 1'b1, 5'h03, 8'h60);
      chk({9'h000, page}, 12'h003);
      u_dec.seq(pcb_pkg::PCB_OP_JUMP, 9'h123);
      chk(pc, 12'h723);
      // Programming port: store, user code identifier, fixed part identifier
      u_dec.prg(1'b0, 1'b1, 13'h1005, 12'h321);
      u_dec.prg(1'b1, 1'b0, 13'h1005, 12'h000);
      chk(prog_rdata, 12'h321);
      u_dec.prg(1'b1, 1'b0, 13'h0200, 12'h000);
      chk(prog_rdata, 12'hABC);
      u_dec.prg(1'b0, 1'b1, 13'h1010, 12'h000);
      u_dec.prg(1'b1, 1'b0, 13'h1010, 12'h000);
      chk(prog_rdata, pcb_pkg::DEVID_DEFAULT);
      // Reset again in mid-run
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      #1;
      chk(pc, 12'hFFF);
      chk({9'h000, page}, 12'h000);
      chk({4'h0, rdata}, 12'h000);
      chk(prog_rdata, 12'h000);
      u_dec.seq(pcb_pkg::PCB_OP_STEP, 9'h000);
      chk(pc, 12'h000);
      summarize();
   end
endmodule : program_counter_banked_data_addressing_tb_top
